// ---- src/hrel_pkg.sv ----
// constants and register map of the handset regulator enable logic
`default_nettype none

package hrel_pkg;
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  CTRL_ADDR       = 4'h0;
  localparam logic [3:0]  STATUS_ADDR     = 4'h4;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  // control register fields
  localparam int unsigned CTRL_W          = 5;
  localparam int unsigned CTRL_HOLD_BIT   = 0;
  localparam int unsigned CTRL_SIM_BIT    = 1;
  localparam int unsigned CTRL_OSC_BIT    = 2;
  localparam int unsigned CTRL_GATE_BIT   = 3;
  localparam int unsigned CTRL_CHARGER_GATE_ENABLE_BIT  = 4;
  localparam logic [4:0]  CTRL_RESET      = 5'h00;
  // status register fields
  localparam int unsigned ST_ON_BIT       = 0;
  localparam int unsigned ST_CORE_BIT     = 1;
  localparam int unsigned ST_MEM_BIT      = 2;
  localparam int unsigned ST_AN_BIT       = 3;
  localparam int unsigned ST_OSC_BIT      = 4;
  localparam int unsigned ST_SIM_BIT      = 5;
  localparam int unsigned ST_RTC_BIT      = 6;
  localparam int unsigned ST_DIVBAT_BIT   = 7;
  localparam int unsigned ST_GATE_BIT     = 8;
  localparam int unsigned ST_KEY_BIT      = 9;
  localparam int unsigned ST_RESET_BIT    = 10;
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned RESET_DELAY_NS  = 100000;
  localparam int unsigned RESET_DELAY_CYCLES =
    (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : hrel_pkg

`default_nettype wire

// ---- src/hrel_reset_timer.sv ----
// reset delay timer: counts from core regulation to main reset release
`default_nettype none

module hrel_reset_timer
  import hrel_pkg::*;
#(
  parameter int unsigned CYCLES = RESET_DELAY_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  output logic      done
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 1) begin : g_bad_cycles
      $error("reset delay must be at least one cycle");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } hrel_tmr_t;

  hrel_tmr_t s_ff;
  hrel_tmr_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (!run) begin
      nxt_s = '0; // losing regulation restarts the delay
    end else if (!s_ff.done) begin
      if (s_ff.cnt == CW'(CYCLES - 1)) begin
        nxt_s.done = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done = s_ff.done;

  a_done_after_count: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(done) |-> $past(run) && $past(s_ff.cnt) == CW'(CYCLES - 1))
    else $error("reset released before the delay ran out");

  a_done_drops_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !run |=> !done && s_ff.cnt == '0)
    else $error("reset timer kept running without core regulation");
endmodule : hrel_reset_timer

`default_nettype wire

// ---- src/hrel_top.sv ----
// regulator enable logic with an axi4-lite control and status port
`default_nettype none

module hrel_top
  import hrel_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RESET_DELAY_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // supervisory and pin inputs
  input  wire logic              deep_discharge_lockout_n,
  input  wire logic              undervoltage_lockout_n,
  input  wire logic              charger_detect,
  input  wire logic              user_power_key_n,
  input  wire logic              core_in_regulation,
  input  wire logic              charger_auto_drive,
  // supply enables and outputs
  output logic                   core_supply,
  output logic                   memory_supply,
  output logic                   analog_supply,
  output logic                   reference_output,
  output logic                   oscillator_supply,
  output logic                   sim_supply,
  output logic                   rtc_supply,
  output logic                   divided_battery_output,
  output logic                   charger_gate_drive,
  output logic                   key_sense_output,
  output logic                   main_reset_out
);

  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [CTRL_W-1:0] w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [CTRL_W-1:0] ctrl;
    logic              phone_on;
    logic              core;
    logic              mem;
    logic              an;
    logic              osc;
    logic              sim;
    logic              rtc;
    logic              divbat;
    logic              gate;
    logic              key;
  } hrel_state_t;

  hrel_state_t s_ff;
  hrel_state_t nxt_s;
  logic        reset_done;
  logic        key_pressed;
  logic        hold;
  logic        sim_en;
  logic        osc_en;
  logic        want_on;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;

  assign key_pressed   = !user_power_key_n;
  assign hold          = s_ff.ctrl[CTRL_HOLD_BIT];  // held as a level by software
  assign sim_en        = s_ff.ctrl[CTRL_SIM_BIT];
  assign osc_en        = s_ff.ctrl[CTRL_OSC_BIT];
  assign want_on       = key_pressed || hold || charger_detect;
  assign s_axi_awready = !s_ff.aw_got && !s_ff.bvalid;
  assign s_axi_wready  = !s_ff.w_got && !s_ff.bvalid;
  assign s_axi_arready = !s_ff.rvalid;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;

  hrel_reset_timer #(
    .CYCLES (RESET_CYCLES)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (s_ff.core && core_in_regulation),
    .done    (reset_done)
  );

  always_comb begin
    nxt_s = s_ff;
    // bus side
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (aw_hs) begin
      nxt_s.aw_got  = 1'b1;
      nxt_s.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      nxt_s.w_got   = 1'b1;
      nxt_s.w_data  = s_axi_wdata[CTRL_W-1:0];
      nxt_s.w_lane0 = s_axi_wstrb[0];
    end
    // address and data may arrive in either order; commit once both are in
    if (nxt_s.aw_got && nxt_s.w_got && !s_ff.bvalid) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got  = 1'b0;
      nxt_s.bvalid = 1'b1;
      if (nxt_s.aw_addr == CTRL_ADDR) begin
        nxt_s.bresp = RESP_OKAY;
        if (nxt_s.w_lane0) begin
          nxt_s.ctrl = nxt_s.w_data;
        end
      end else if (nxt_s.aw_addr == STATUS_ADDR) begin
        nxt_s.bresp = RESP_OKAY; // read-only, write ignored
      end else begin
        nxt_s.bresp = RESP_SLVERR;
      end
    end
    if (ar_hs) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = RESP_OKAY;
      nxt_s.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        CTRL_ADDR: begin
          nxt_s.rdata[CTRL_W-1:0] = s_ff.ctrl;
        end
        STATUS_ADDR: begin
          nxt_s.rdata[ST_ON_BIT]     = s_ff.phone_on;
          nxt_s.rdata[ST_CORE_BIT]   = s_ff.core;
          nxt_s.rdata[ST_MEM_BIT]    = s_ff.mem;
          nxt_s.rdata[ST_AN_BIT]     = s_ff.an;
          nxt_s.rdata[ST_OSC_BIT]    = s_ff.osc;
          nxt_s.rdata[ST_SIM_BIT]    = s_ff.sim;
          nxt_s.rdata[ST_RTC_BIT]    = s_ff.rtc;
          nxt_s.rdata[ST_DIVBAT_BIT] = s_ff.divbat;
          nxt_s.rdata[ST_GATE_BIT]   = s_ff.gate;
          nxt_s.rdata[ST_KEY_BIT]    = s_ff.key; // key polled here too
          nxt_s.rdata[ST_RESET_BIT]  = reset_done;
        end
        default: begin
          nxt_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    // enable logic; the undervoltage lockout only gates turn-on, never a running phone
    nxt_s.phone_on = deep_discharge_lockout_n && want_on
                     && (undervoltage_lockout_n || s_ff.phone_on);
    nxt_s.core   = nxt_s.phone_on;
    nxt_s.mem    = nxt_s.phone_on;
    nxt_s.an     = nxt_s.phone_on && (key_pressed || charger_detect || osc_en);
    nxt_s.osc    = nxt_s.phone_on && (key_pressed || charger_detect || osc_en);
    nxt_s.sim    = nxt_s.phone_on && hold && sim_en
                   && !key_pressed && !charger_detect;
    nxt_s.divbat = nxt_s.phone_on && osc_en && hold
                   && !key_pressed && !charger_detect;
    nxt_s.rtc    = deep_discharge_lockout_n;
    nxt_s.gate   = s_ff.ctrl[CTRL_CHARGER_GATE_ENABLE_BIT] ? s_ff.ctrl[CTRL_GATE_BIT]
                                             : charger_auto_drive;
    nxt_s.key    = key_pressed;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff      <= '0;
      s_ff.ctrl <= CTRL_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign s_axi_bvalid           = s_ff.bvalid;
  assign s_axi_bresp            = s_ff.bresp;
  assign s_axi_rvalid           = s_ff.rvalid;
  assign s_axi_rdata            = s_ff.rdata;
  assign s_axi_rresp            = s_ff.rresp;
  assign core_supply            = s_ff.core;
  assign memory_supply          = s_ff.mem;
  assign analog_supply          = s_ff.an;
  assign reference_output       = s_ff.an;
  assign oscillator_supply      = s_ff.osc;
  assign sim_supply             = s_ff.sim;
  assign rtc_supply             = s_ff.rtc;
  assign divided_battery_output = s_ff.divbat;
  assign charger_gate_drive     = s_ff.gate;
  assign key_sense_output       = s_ff.key;
  assign main_reset_out         = reset_done;

  sequence seq_key_start;
    aresetn && key_pressed && deep_discharge_lockout_n && undervoltage_lockout_n;
  endsequence
  sequence seq_key_kept;
    key_pressed && deep_discharge_lockout_n;
  endsequence

  a_deep_all_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !deep_discharge_lockout_n |=> !core_supply && !memory_supply && !analog_supply
      && !oscillator_supply && !sim_supply && !rtc_supply && !divided_battery_output)
    else $error("supply left on under deep-discharge lockout");

  a_uvlo_blocks_on: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && !undervoltage_lockout_n && !s_ff.phone_on |=> !core_supply && !analog_supply
      && (rtc_supply == $past(deep_discharge_lockout_n)))
    else $error("turn-on allowed under undervoltage lockout");

  a_uvlo_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ff.phone_on && deep_discharge_lockout_n && want_on |=> core_supply && memory_supply)
    else $error("running phone dropped by undervoltage lockout");

  a_hold_core_mem: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ff.phone_on && deep_discharge_lockout_n && hold && !key_pressed
      && !charger_detect && !osc_en
    |=> core_supply && memory_supply && !analog_supply && !oscillator_supply)
    else $error("power hold alone did not give core and memory only");

  a_divbat_osc: assert property (@(posedge aclk) disable iff (!aresetn)
    divided_battery_output |-> $past(osc_en) && s_ff.phone_on && oscillator_supply)
    else $error("battery output on without osc enable or phone on");

  a_key_sense: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn |=> key_sense_output == $past(key_pressed))
    else $error("key sense does not follow the power key");

  a_gate_steer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ff.ctrl[CTRL_CHARGER_GATE_ENABLE_BIT] |=> charger_gate_drive == $past(s_ff.ctrl[CTRL_GATE_BIT]))
    else $error("gate drive ignores processor gate input");

  a_key_held_on: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_key_start ##1 seq_key_kept[*2] |=> core_supply && analog_supply
      && oscillator_supply && memory_supply && !sim_supply)
    else $error("held key did not keep supplies on");

  a_sim_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    sim_supply |-> $past(hold) && $past(sim_en) && core_supply)
    else $error("sim supply on without enable and power hold");

  a_charger_on: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && charger_detect && deep_discharge_lockout_n && undervoltage_lockout_n
    |=> core_supply && analog_supply && oscillator_supply && memory_supply
      && !sim_supply && !divided_battery_output)
    else $error("charger did not give the charging supply set");
endmodule : hrel_top

`default_nettype wire

// ---- dv/hrel_proc_model.sv ----
// processor-side model: axi4-lite master that drives the power control register
`default_nettype none

module hrel_proc_model (
  input  wire logic        aclk,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [3:0]       s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [3:0]       s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ns;

  // answers always accepted at once, so ready lines stay high
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
  end

  // hold, sim and osc enables stay as levels in ctrl until rewritten
  // no cycle limit of its own: only the bench watchdog ends a wait
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule // hrel_proc_model

`default_nettype wire

// ---- dv/tb_hrel_top.sv ----
// self-checking bench for the regulator enable logic
`default_nettype none

module tb_hrel_top
  import hrel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // short reset delay keeps the run brief
  localparam int unsigned RC = 4;

  typedef struct packed {
    logic [6:0] pin;
    logic [7:0] exp;
  } hrel_row_t;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        deep_discharge_lockout_n = 1'b1;
  logic        undervoltage_lockout_n = 1'b1;
  logic        charger_detect = 1'b0;
  logic        user_power_key_n = 1'b1;
  logic        core_in_regulation = 1'b0;
  logic        charger_auto_drive = 1'b0;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  wire logic [10:0] outs;
  int          fail_count = 0;
  int          check_count = 0;
  // pin: lockout_n, uvlo_n, charger, key_n, osc, sim, hold; exp: supplies
  hrel_row_t   rows [12] = '{
    '{7'h37, 8'h00}, '{7'h57, 8'h02}, '{7'h68, 8'h02}, '{7'h78, 8'hfa},
    '{7'h60, 8'hfa}, '{7'h69, 8'hc2}, '{7'h49, 8'hc2}, '{7'h4b, 8'hc6},
    '{7'h6f, 8'hff}, '{7'h6e, 8'h02}, '{7'h7e, 8'hfa}, '{7'h67, 8'hfa}};

  always #20 aclk = ~aclk;

  hrel_top #(.RESET_CYCLES(RC)) i_dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .deep_discharge_lockout_n, .undervoltage_lockout_n,
    .charger_detect, .user_power_key_n, .core_in_regulation, .charger_auto_drive,
    .core_supply(outs[10]), .memory_supply(outs[9]), .analog_supply(outs[8]),
    .reference_output(outs[7]), .oscillator_supply(outs[6]), .sim_supply(outs[5]),
    .rtc_supply(outs[4]), .divided_battery_output(outs[3]), .charger_gate_drive(outs[2]),
    .key_sense_output(outs[1]), .main_reset_out(outs[0])
  );

  hrel_proc_model i_proc (
    .aclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp}, "bus response");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    chk({21'h0, outs}, 32'h0, "outputs in reset");
    aresetn <= 1'b1;
    @(posedge aclk);
    i_proc.rd(CTRL_ADDR, rd, resp);
    chk(rd, {27'h0, CTRL_RESET}, "ctrl reset value");
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      {deep_discharge_lockout_n, undervoltage_lockout_n, charger_detect, user_power_key_n}
        <= rows[i].pin[6:3];
      i_proc.wr(CTRL_ADDR, {29'h0, rows[i].pin[2:0]}, 4'hf, resp);
      repeat (3) @(posedge aclk);
      chk({24'h0, outs[10:3]}, {24'h0, rows[i].exp}, "supplies");
    end
    for (int k = 0; k < 2; k++) begin
      user_power_key_n <= k[0];
      repeat (3) @(posedge aclk);
      chk({31'h0, outs[1]}, {31'h0, ~k[0]}, "key sense");
      // status word: key held gives no sim and no battery output
      i_proc.rd(STATUS_ADDR, rd, resp);
      chk_resp(resp, RESP_OKAY);
      chk(rd, k[0] ? 32'h0000_00ff : 32'h0000_025f, "status word");
    end
    // every gate enable, gate and auto-drive combination, with the phone held on
    for (int j = 0; j < 8; j++) begin
      charger_auto_drive <= j[0];
      i_proc.wr(CTRL_ADDR, {27'h0, j[2], j[1], 3'h1}, 4'hf, resp);
      repeat (3) @(posedge aclk);
      chk({31'h0, outs[2]}, {31'h0, j[2] ? j[1] : j[0]}, "gate drive");
    end
    core_in_regulation <= 1'b1;
    repeat (RC) @(posedge aclk);
    chk({31'h0, outs[0]}, 32'h0, "main reset early");
    repeat (3) @(posedge aclk);
    chk({31'h0, outs[0]}, 32'h1, "main reset late");
    core_in_regulation <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({31'h0, outs[0]}, 32'h0, "main reset drop");
    // unmapped, read-only and strobe-less accesses must leave ctrl alone
    i_proc.wr(4'h8, 32'h0, 4'hf, resp);
    chk_resp(resp, RESP_SLVERR);
    i_proc.rd(4'hc, rd, resp);
    chk_resp(resp, RESP_SLVERR);
    chk(rd, 32'h0, "unmapped read");
    i_proc.wr(STATUS_ADDR, 32'h0, 4'hf, resp);
    chk_resp(resp, RESP_OKAY);
    i_proc.wr(CTRL_ADDR, 32'h0, 4'h0, resp);
    chk_resp(resp, RESP_OKAY);
    i_proc.rd(CTRL_ADDR, rd, resp);
    chk(rd, 32'h19, "ctrl kept");
    do_reset();
    print_verdict();
  end

  initial begin
    repeat (4000) @(posedge aclk);
    fail_count++;
    print_verdict();
  end
endmodule // tb_hrel_top

`default_nettype wire
